// file: hw/gam_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef GAM_REGS_SVH
`define GAM_REGS_SVH
`define GAM_OFS_FSEL_LO    8'h00
`define GAM_OFS_FSEL_HI    8'h04
`define GAM_OFS_DIR        8'h08
`define GAM_OFS_GOUT       8'h0C
`define GAM_OFS_CTRL       8'h10
`define GAM_OFS_FMASK      8'h14
`define GAM_OFS_ISTAT      8'h18
`define GAM_OFS_IMASK      8'h1C
`define GAM_OFS_STATUS     8'h20
`define GAM_CTRL_RATE_LSB  0
`define GAM_CTRL_KEEP_BIT  4
`define GAM_CTRL_HOLD_BIT  5
`define GAM_CTRL_SINK_LSB  6
`define GAM_CTRL_RLEN_LSB  8
`define GAM_CTRL_FLEN_LSB  16
`define GAM_CTRL_TRIG_BIT  24
`define GAM_DIR_RST        13'h1FFF
`define GAM_IMASK_RST      3'h7
`define GAM_CLK_HZ         25000000
`define GAM_PCLK_HZ        1000000
`define GAM_PCLK_DIV       (`GAM_CLK_HZ / `GAM_PCLK_HZ)
`define GAM_RST_UNIT_NS    1000
`define GAM_RST_UNIT_CYC   ((`GAM_RST_UNIT_NS * 25 + 999) / 1000)
`define GAM_FLASH_UNIT_US  1000
`define GAM_FLASH_UNIT_CYC (`GAM_FLASH_UNIT_US * 25)
`endif

// file: hw/gam_pkg.sv
// Types shared by the alternate output selector.
package gam_pkg;
   typedef enum logic [3:0] {
      GAM_FN_GPIO    = 4'h0,
      GAM_FN_POWERED = 4'h1,
      GAM_FN_DEVPROG = 4'h2,
      GAM_FN_PORREL  = 4'h3,
      GAM_FN_SYSRST  = 4'h4,
      GAM_FN_EXT_MEMORY_RESET_N  = 4'h5,
      GAM_FN_CLK32K  = 4'h6,
      GAM_FN_FLASH   = 4'h7,
      GAM_FN_MIC_BIAS_CURRENT_FLAG  = 4'h8,
      GAM_FN_MIC_BIAS_SHORT_FLAG  = 4'h9,
      GAM_FN_PHASE   = 4'hA,
      GAM_FN_RTCDIV  = 4'hB,
      GAM_FN_FAULT   = 4'hC
   } gam_fn_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } gam_apb_req_s;

   typedef struct packed {
      logic [51:0] fsel;
      logic [12:0] dir;
      logic [12:0] gout;
      logic [3:0]  rate;
      logic        keep;
      logic        hold;
      logic [1:0]  sink;
      logic [7:0]  rlen;
      logic [7:0]  flen;
      logic [7:0]  fmask;
      logic [2:0]  ist;
      logic [2:0]  imask;
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [4:0]  s3;
      logic [15:0] rtc_cnt;
      logic [4:0]  pdiv;
      logic [15:0] rst_cnt;
      logic [23:0] fl_cnt;
      logic        rst_prev;
      logic        flt_prev;
      logic [12:0] pin_o;
      logic [12:0] pin_oe;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } gam_state_s;
endpackage : gam_pkg

// file: hw/gam_alt_out.sv
// Alternate output function selector for the general purpose pins.
`include "gam_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module gam_alt_out
   import gam_pkg::*;
#(
   parameter int unsigned FLASH_UNIT_CYC = `GAM_FLASH_UNIT_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [31:0]      prdata_out,
   output logic             irq_out,
   input  wire logic        powered_on_in,
   input  wire logic        off_state_in,
   input  wire logic        pre_active_in,
   input  wire logic        hibernate_in,
   input  wire logic        por_release_in,
   input  wire logic        sys_reset_active_in,
   input  wire logic        manual_reset_n_in,
   input  wire logic        rtc_osc_32k_in,
   input  wire logic        mic_current_det_in,
   input  wire logic        mic_short_det_in,
   input  wire logic        flash_pin_in,
   input  wire logic        dcdc_phase_sync_in,
   input  wire logic [7:0]  supply_fault_src_in,
   input  wire logic        four_wire_mode_in,
   input  wire logic        serial_ctrl_data_out_in,
   input  wire logic        serial_ctrl_data_oe_in,
   output logic [12:0]      pin_o_out,
   output logic [12:0]      pin_oe_out
);
   // Synchroniser bit positions.
   localparam int MRN = 0;
   localparam int C32 = 1;
   localparam int MDT = 2;
   localparam int MST = 3;
   localparam int FLP = 4;

   gam_state_s   st_q;
   gam_state_s   st_d;
   gam_apb_req_s req;
   logic [15:0]  alt;
   logic         sys_rst_n;
   logic         fl_trig;
   logic         fault_any;
   logic [2:0]   ev;
   logic [32:0]  rdw;
   logic         setup;
   logic         wr;

   // Function select nibble of one pin.
   function automatic logic [3:0] fn_of(input logic [51:0] f,
                                        input int i);
      return f[4*i +: 4];
   endfunction : fn_of

   // Register read decode; the error flag marks an unmapped offset.
   function automatic logic [32:0] rd_word(input gam_state_s s,
                                           input logic [7:0] a);
      logic [32:0] r;
      r = 33'h0_0000_0000;
      unique case (a)
         `GAM_OFS_FSEL_LO: r[31:0] = s.fsel[31:0];
         `GAM_OFS_FSEL_HI: r[19:0] = s.fsel[51:32];
         `GAM_OFS_DIR:     r[12:0] = s.dir;
         `GAM_OFS_GOUT:    r[12:0] = s.gout;
         `GAM_OFS_CTRL:    r[23:0] = {s.flen, s.rlen, s.sink, s.hold,
                                      s.keep, s.rate};
         `GAM_OFS_FMASK:   r[7:0]  = s.fmask;
         `GAM_OFS_ISTAT:   r[2:0]  = s.ist;
         `GAM_OFS_IMASK:   r[2:0]  = s.imask;
         `GAM_OFS_STATUS:  r[28:0] = {s.s2[MST:MDT], s.fl_cnt != 24'h0,
                                      s.pin_oe, s.pin_o};
         default:          r[32]   = 1'b1;
      endcase
      return r;
   endfunction : rd_word

   assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                  paddr: paddr_in, pwdata: pwdata_in};

   always_comb begin
      st_d = st_q;
      // Pin inputs pass two flip-flops; the third stage feeds edge logic.
      st_d.s1 = {flash_pin_in, mic_short_det_in, mic_current_det_in,
                 rtc_osc_32k_in, manual_reset_n_in};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;

      // Zero-wait APB: answer in the first access cycle.
      setup = req.psel & ~req.penable;
      wr = req.psel & req.penable & req.pwrite & st_q.pready;
      rdw = rd_word(st_q, req.paddr);
      st_d.pready = setup;
      st_d.pslverr = setup & rdw[32];
      st_d.prdata = setup ? rdw[31:0] : 32'h0;

      fl_trig = 1'b0;
      if (wr) begin
         unique case (req.paddr)
            `GAM_OFS_FSEL_LO: st_d.fsel[31:0] = req.pwdata;
            `GAM_OFS_FSEL_HI: st_d.fsel[51:32] = req.pwdata[19:0];
            `GAM_OFS_DIR:     st_d.dir = req.pwdata[12:0];
            `GAM_OFS_GOUT:    st_d.gout = req.pwdata[12:0];
            `GAM_OFS_CTRL: begin
               st_d.rate = req.pwdata[`GAM_CTRL_RATE_LSB +: 4];
               st_d.keep = req.pwdata[`GAM_CTRL_KEEP_BIT];
               st_d.hold = req.pwdata[`GAM_CTRL_HOLD_BIT];
               st_d.sink = req.pwdata[`GAM_CTRL_SINK_LSB +: 2];
               st_d.rlen = req.pwdata[`GAM_CTRL_RLEN_LSB +: 8];
               st_d.flen = req.pwdata[`GAM_CTRL_FLEN_LSB +: 8];
               fl_trig = req.pwdata[`GAM_CTRL_TRIG_BIT];
            end
            `GAM_OFS_FMASK:   st_d.fmask = req.pwdata[7:0];
            `GAM_OFS_IMASK:   st_d.imask = req.pwdata[2:0];
            default: ;
         endcase
      end

      // Flash runs for the programmed length from a pin edge or the
      // trigger bit, through either enabled current sink.
      fl_trig = (fl_trig | (st_q.s2[FLP] & ~st_q.s3[FLP]))
                & |st_q.sink;
      if (fl_trig) begin
         st_d.fl_cnt = 24'(st_q.flen * FLASH_UNIT_CYC);
      end else if (st_q.fl_cnt != 24'h0) begin
         st_d.fl_cnt = st_q.fl_cnt - 24'h1;
      end

      // Reset output stays low a programmed time after reset ends.
      st_d.rst_prev = sys_reset_active_in;
      if (st_q.rst_prev & ~sys_reset_active_in) begin
         st_d.rst_cnt = 16'(st_q.rlen * `GAM_RST_UNIT_CYC);
      end else if (st_q.rst_cnt != 16'h0) begin
         st_d.rst_cnt = st_q.rst_cnt - 16'h1;
      end
      // The cycle that sees reset end stays low while the count loads.
      sys_rst_n = ~sys_reset_active_in & ~st_q.rst_prev & st_q.s2[MRN]
                  & (st_q.rst_cnt == 16'h0);

      // Phase clock restarts on each converter switching edge.
      if (dcdc_phase_sync_in ||
          st_q.pdiv == 5'(`GAM_PCLK_DIV - 1)) begin
         st_d.pdiv = 5'h00;
      end else begin
         st_d.pdiv = st_q.pdiv + 5'h01;
      end

      if (st_q.s2[C32] & ~st_q.s3[C32]) begin
         st_d.rtc_cnt = st_q.rtc_cnt + 16'h0001;
      end

      fault_any = |(supply_fault_src_in & ~st_q.fmask);
      st_d.flt_prev = fault_any;

      alt = 16'h0000;
      alt[GAM_FN_POWERED] = powered_on_in & ~off_state_in;
      alt[GAM_FN_DEVPROG] = pre_active_in
                            | alt[GAM_FN_POWERED]
                            | (off_state_in & st_q.hold);
      alt[GAM_FN_PORREL] = por_release_in;
      alt[GAM_FN_SYSRST] = sys_rst_n;
      alt[GAM_FN_EXT_MEMORY_RESET_N] = hibernate_in ? st_q.keep
                                        : sys_rst_n;
      alt[GAM_FN_CLK32K] = st_q.s2[C32];
      alt[GAM_FN_FLASH] = st_q.fl_cnt != 24'h0;
      alt[GAM_FN_MIC_BIAS_CURRENT_FLAG] = st_q.s2[MDT];
      alt[GAM_FN_MIC_BIAS_SHORT_FLAG] = st_q.s2[MST];
      alt[GAM_FN_PHASE] = st_q.pdiv < 5'(`GAM_PCLK_DIV / 2);
      alt[GAM_FN_RTCDIV] = st_q.rtc_cnt[st_q.rate];
      alt[GAM_FN_FAULT] = ~fault_any;

      // The mux is registered, so a select change cannot glitch a pin.
      for (int i = 0; i < 13; i++) begin
         st_d.pin_oe[i] = ~st_q.dir[i];
         st_d.pin_o[i] = (fn_of(st_q.fsel, i) == GAM_FN_GPIO)
                         ? st_q.gout[i]
                         : alt[fn_of(st_q.fsel, i)];
      end
      if (four_wire_mode_in) begin
         st_d.pin_o[6] = serial_ctrl_data_out_in;
         st_d.pin_oe[6] = serial_ctrl_data_oe_in;
      end

      // A new event wins over a clear in the same cycle.
      ev = {fault_any & ~st_q.flt_prev,
            st_q.s2[MST] & ~st_q.s3[MST],
            st_q.s2[MDT] & ~st_q.s3[MDT]};
      if (wr && req.paddr == `GAM_OFS_ISTAT) begin
         st_d.ist = st_q.ist & ~req.pwdata[2:0];
      end
      st_d.ist = st_d.ist | ev;
      st_d.irq = |(st_d.ist & ~st_d.imask);
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q <= '0;
         st_q.dir <= `GAM_DIR_RST;
         st_q.imask <= `GAM_IMASK_RST;
         st_q.s1 <= 5'h01;
         st_q.s2 <= 5'h01;
         st_q.s3 <= 5'h01;
      end else begin
         st_q <= st_d;
      end
   end

   assign pready_out = st_q.pready;
   assign pslverr_out = st_q.pslverr;
   assign prdata_out = st_q.prdata;
   assign irq_out = st_q.irq;
   assign pin_o_out = st_q.pin_o;
   assign pin_oe_out = st_q.pin_oe;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence rst_release_s;
      $fell(sys_reset_active_in) && st_q.rlen != 8'h00;
   endsequence
   sequence pin0_rst_sel_s;
      fn_of(st_q.fsel, 0) == GAM_FN_SYSRST && !st_q.dir[0];
   endsequence

   flash_start_a: assert property (fl_trig && st_q.flen != 8'h00 |=>
      st_q.fl_cnt != 24'h0 ##1 st_q.fl_cnt != 24'h0)
      else $error("flash did not start");
   mic_event_a: assert property ($rose(st_q.s2[MDT]) |=> st_q.ist[0])
      else $error("mic detect event lost");
   short_event_a: assert property ($rose(st_q.s2[MST]) |=> st_q.ist[1])
      else $error("mic short event lost");
   phase_period_a: assert property ($rose(alt[GAM_FN_PHASE]) |->
      ##[1:25] $rose(alt[GAM_FN_PHASE]))
      else $error("phase clock stalled");
   rst_stretch_a: assert property (pin0_rst_sel_s ##0 rst_release_s
      |=> !st_q.pin_o[0] [*2])
      else $error("reset pulse not stretched");
   four_wire_a: assert property (four_wire_mode_in |=>
      st_q.pin_o[6] == $past(serial_ctrl_data_out_in))
      else $error("pin 6 not serial data");
   fault_mask_a: assert property (fn_of(st_q.fsel, 3) == GAM_FN_FAULT
      && !st_q.dir[3] && (supply_fault_src_in & ~st_q.fmask) == 8'h00
      |=> st_q.pin_o[3])
      else $error("masked fault reached pin");
   gpio_plain_a: assert property (fn_of(st_q.fsel, 2) == GAM_FN_GPIO
      |=> st_q.pin_o[2] == $past(st_q.gout[2]))
      else $error("gpio value not driven");
   dir_input_a: assert property (st_q.dir[3] |=> !st_q.pin_oe[3])
      else $error("input pin driven");
   mem_keep_a: assert property (hibernate_in && st_q.keep
      && fn_of(st_q.fsel, 0) == GAM_FN_EXT_MEMORY_RESET_N |=> st_q.pin_o[0])
      else $error("memory reset in hibernate");
endmodule : gam_alt_out
`default_nettype wire

// file: verification/gam_board_model.sv
// Board-side sources: a shortened 32 kHz oscillator and converter sync.
`timescale 1ns/1ps
`default_nettype none
module gam_board_model #(
   parameter int OSC_HALF = 8,
   parameter int SYNC_PER = 25
) (
   input  wire logic clk_in,
   output logic      osc_out,
   output logic      sync_out
);
   // The oscillator is far faster than the real one so periods fit the run.
   int oc = 0;
   int sc = 0;
   logic osc_q = 1'h0;
   logic sync_q = 1'h0;
   assign osc_out = osc_q;
   assign sync_out = sync_q;
   always @(posedge clk_in) begin
      oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
      if (oc == OSC_HALF - 1) osc_q <= ~osc_q;
      sc <= (sc == SYNC_PER - 1) ? 0 : sc + 1;
      sync_q <= (sc == SYNC_PER - 1);
   end
endmodule : gam_board_model
`default_nettype wire

// file: verification/tb_gam_alt_out.sv
// Self-checking bench for the alternate output selector.
`include "gam_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_gam_alt_out;
   import gam_pkg::*;
   logic        clk_in = 1'h0;
   logic        sys_rst_in = 1'h1;
   logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0, err;
   logic [7:0]  paddr = 8'h00, fsrc = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prd;
   logic [6:0]  st = 7'h40;
   logic        mic_c = 1'h0, mic_s = 1'h0, fpin = 1'h0;
   logic        fw = 1'h0, sdo = 1'h0, sdoe = 1'h0;
   logic        prdy, pslv, irq, osc, sync, a;
   logic [12:0] po, poe;
   int          err_total = 0;
   int          n_compared = 0;
   // Rows: code, ctrl bits 7:4, state {man_n,sysrst,por,hib,pre,off,pwr}, pin.
   logic [19:0] rows [13] = '{20'h1_0_41_1, 20'h1_0_42_0, 20'h2_0_44_1,
      20'h2_0_42_0, 20'h2_2_42_1, 20'h3_0_50_1, 20'h3_0_40_0, 20'h4_0_60_0,
      20'h4_0_40_1, 20'h4_0_00_0, 20'h5_0_40_1, 20'h5_0_48_0, 20'h5_1_48_1};

   gam_alt_out #(.FLASH_UNIT_CYC(2)) dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pready_out(prdy), .pslverr_out(pslv),
      .prdata_out(prd), .irq_out(irq), .powered_on_in(st[0]),
      .off_state_in(st[1]), .pre_active_in(st[2]), .hibernate_in(st[3]),
      .por_release_in(st[4]), .sys_reset_active_in(st[5]),
      .manual_reset_n_in(st[6]), .rtc_osc_32k_in(osc),
      .mic_current_det_in(mic_c), .mic_short_det_in(mic_s),
      .flash_pin_in(fpin), .dcdc_phase_sync_in(sync),
      .supply_fault_src_in(fsrc), .four_wire_mode_in(fw),
      .serial_ctrl_data_out_in(sdo), .serial_ctrl_data_oe_in(sdoe),
      .pin_o_out(po), .pin_oe_out(poe));
   gam_board_model board (.clk_in(clk_in), .osc_out(osc), .sync_out(sync));

   initial forever #20 clk_in = ~clk_in;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc

   // Ready is sampled at a rising edge; the request stands until then.
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1'h1;
      do begin
         @(posedge clk_in);
         n++;
         if (n > 20) begin
            err_total++;
            conclude();
         end
      end while (prdy !== 1'h1);
      rd = prd;
      err = pslv;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : bus

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus(1'h1, ad, d);
   endtask : wr

   task automatic rdr(input logic [7:0] ad);
      bus(1'h0, ad, 32'h0);
   endtask : rdr

   task automatic osc_rise();
      int n;
      n = 0;
      while (osc !== 1'h0 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      while (osc !== 1'h1 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 40) begin
         err_total++;
         conclude();
      end
      cyc(5);
   endtask : osc_rise

   task automatic t_reset();
      chk(poe, 13'h0);
      chk(irq, 1'h0);
      rdr(`GAM_OFS_DIR);
      chk(rd, 32'h1FFF);
      rdr(`GAM_OFS_IMASK);
      chk(rd, 32'h7);
      rdr(8'h24);
      chk(err, 1'h1);
      chk(rd, 32'h0);
   endtask : t_reset

   task automatic t_gpio();
      wr(`GAM_OFS_GOUT, 32'h1A5A);
      wr(`GAM_OFS_DIR, 32'h0F00);
      cyc(2);
      chk(po & poe, 13'h105A);
      chk(poe, 13'h10FF);
      wr(`GAM_OFS_DIR, 32'h0);
   endtask : t_gpio

   task automatic t_table();
      foreach (rows[i]) begin
         wr(`GAM_OFS_CTRL, {24'h0, rows[i][15:12], 4'h0});
         wr(`GAM_OFS_FSEL_LO, {28'hB06AC98, rows[i][19:16]});
         @(posedge clk_in);
         st <= rows[i][10:4];
         cyc(8);
         chk(po[0], rows[i][0]);
      end
   endtask : t_table

   task automatic t_rlen();
      int n;
      n = 0;
      wr(`GAM_OFS_FSEL_LO, 32'hB06AC984);
      wr(`GAM_OFS_CTRL, 32'h100);
      @(posedge clk_in);
      st <= 7'h60;
      cyc(4);
      @(posedge clk_in);
      st <= 7'h40;
      cyc(1);
      while (po[0] !== 1'h1 && n < 100) begin
         n++;
         cyc(1);
      end
      chk(n >= 25 && n <= 28, 1'h1);
   endtask : t_rlen

   task automatic t_mic();
      wr(`GAM_OFS_IMASK, 32'h0);
      @(posedge clk_in);
      mic_c <= 1'h1;
      cyc(6);
      chk(po[2:1], 2'h1);
      chk(irq, 1'h1);
      rdr(`GAM_OFS_ISTAT);
      chk(rd, 32'h1);
      wr(`GAM_OFS_IMASK, 32'h1);
      cyc(1);
      chk(irq, 1'h0);
      wr(`GAM_OFS_ISTAT, 32'h1);
      @(posedge clk_in);
      mic_c <= 1'h0;
      mic_s <= 1'h1;
      cyc(6);
      chk(po[2:1], 2'h2);
      chk(irq, 1'h1);
      rdr(`GAM_OFS_ISTAT);
      chk(rd, 32'h2);
      @(posedge clk_in);
      mic_s <= 1'h0;
      wr(`GAM_OFS_ISTAT, 32'h2);
      cyc(4);
      chk(po[2:1], 2'h0);
      chk(irq, 1'h0);
   endtask : t_mic

   task automatic t_fault();
      wr(`GAM_OFS_FMASK, 32'hFE);
      @(posedge clk_in);
      fsrc <= 8'h01;
      cyc(4);
      chk(po[3], 1'h0);
      @(posedge clk_in);
      fsrc <= 8'h02;
      cyc(4);
      chk(po[3], 1'h1);
      rdr(`GAM_OFS_ISTAT);
      chk(rd, 32'h4);
   endtask : t_fault

   task automatic t_fw();
      @(posedge clk_in);
      fw <= 1'h1;
      sdo <= 1'h0;
      sdoe <= 1'h1;
      cyc(3);
      chk({poe[6], po[6]}, 2'h2);
      @(posedge clk_in);
      sdo <= 1'h1;
      cyc(3);
      chk(po[6], 1'h1);
      @(posedge clk_in);
      fw <= 1'h0;
      sdo <= 1'h0;
      cyc(3);
      chk(po[6], 1'h1);
   endtask : t_fw

   task automatic t_clk();
      int h;
      h = 0;
      repeat (100) begin
         cyc(1);
         h += po[4];
      end
      chk(h, 48);
      osc_rise();
      chk(po[5], 1'h1);
      a = po[7];
      osc_rise();
      chk(po[7], !a);
      wr(`GAM_OFS_CTRL, 32'h1);
      osc_rise();
      a = po[7];
      osc_rise();
      osc_rise();
      chk(po[7], !a);
   endtask : t_clk

   task automatic t_flash();
      int h;
      wr(`GAM_OFS_FSEL_HI, 32'h7);
      for (int s = 1; s >= 0; s--) begin
         h = 0;
         // Sink and length must be set before the write that triggers.
         wr(`GAM_OFS_CTRL, 32'h00020000 | (s << 6));
         wr(`GAM_OFS_CTRL, 32'h01020000 | (s << 6));
         repeat (40) begin
            cyc(1);
            h += po[8];
         end
         chk(h, s * 4);
      end
      wr(`GAM_OFS_CTRL, 32'h00020080);
      h = 0;
      @(posedge clk_in);
      fpin <= 1'h1;
      repeat (40) begin
         cyc(1);
         h += po[8];
      end
      @(posedge clk_in);
      fpin <= 1'h0;
      chk(h, 4);
   endtask : t_flash

   initial begin
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      t_reset();
      t_gpio();
      t_table();
      t_rlen();
      t_mic();
      t_fault();
      t_fw();
      t_clk();
      t_flash();
      conclude();
   end
endmodule : tb_gam_alt_out
`default_nettype wire
